// [verilog/eoc_consts.svh]
// Constants for the encoder output configuration block.
`ifndef EOC_CONSTS_SVH
`define EOC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EOC_OFS_QCFG      4'h7
`define EOC_OFS_LOCK      4'h8
`define EOC_OFS_DIAG      4'h9
`define EOC_OFS_UCFG      4'hA

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define EOC_QCFG_DIR_BIT  9
`define EOC_QCFG_ZMD_BIT  8
`define EOC_QCFG_EN_BIT   7
`define EOC_QCFG_HYS_LSB  4
`define EOC_QCFG_RES_LSB  0
`define EOC_UCFG_EN_BIT   6
`define EOC_UCFG_HYS_LSB  3
`define EOC_UCFG_RES_LSB  0
`define EOC_DIAG_FLUX_BIT 1
`define EOC_DIAG_TRK_BIT  0
`define EOC_QCFG_MASK     12'h3FF
`define EOC_LOCK_MASK     12'h003
`define EOC_DIAG_MASK     12'h003
`define EOC_UCFG_MASK     12'h07F

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define EOC_QCFG_RST      10'h0A0
`define EOC_LOCK_RST      2'h3
`define EOC_DIAG_RST      2'h0
`define EOC_UCFG_RST      7'h52
`define EOC_LOCK_OPEN     2'h3
`define EOC_HYS_BYPASS    3'h0
`define EOC_HYS_ZERO      3'h1
`define EOC_HALF_TURN     12'h800
`define EOC_UVW_SECTORS   6'h06

`endif

// [verilog/eoc_pkg.sv]
// Types shared by the encoder output configuration block.
package eoc_pkg;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h1,
    ST_RUN  = 3'h2,
    ST_USER = 3'h4
  } eoc_state_t;

  typedef struct packed {
    logic       dir;
    logic       zmode;
    logic       en;
    logic [2:0] hys;
    logic [3:0] res;
  } eoc_qcfg_t;

  typedef struct packed {
    logic       en;
    logic [2:0] hys;
    logic [2:0] res;
  } eoc_ucfg_t;

  typedef struct packed {
    logic [11:0] qcfg;
    logic [11:0] lock;
    logic [11:0] diag;
    logic [11:0] ucfg;
  } eoc_nvm_image_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [11:0] wdata;
  } eoc_reg_req_t;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
    logic oe;
  } eoc_quad_pins_t;

  typedef struct packed {
    logic u;
    logic v;
    logic w;
    logic oe;
  } eoc_comm_pins_t;

  typedef struct packed {
    logic [11:0] held;
    logic        dir_up;
  } eoc_hys_state_t;

endpackage

// [verilog/eoc_hys_filter.sv]
// Angle hysteresis filter shared by the quadrature and commutation paths.
`timescale 1ns/1ps
`include "eoc_consts.svh"

module eoc_hys_filter (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [11:0] angle_in,
  input  wire logic [2:0]  hys_code,
  output logic      [11:0] angle_out
);

  eoc_pkg::eoc_hys_state_t st_reg;
  eoc_pkg::eoc_hys_state_t st_next;
  logic signed [11:0]      diff;
  logic [11:0]             mag;
  logic [11:0]             thr;

  // Reversal distance needed before the held angle follows backwards.
  always_comb begin
    case (hys_code)
      3'h1:    thr = 12'h002;
      3'h3:    thr = 12'h003;
      3'h4:    thr = 12'h004;
      default: thr = 12'h002;
    endcase
  end

  assign diff = $signed(angle_in - st_reg.held);
  assign mag  = diff[11] ? 12'(-diff) : 12'(diff);

  // Outside bypass, the held angle follows one LSB per clock so that the outputs never skip a
  // quadrature state. A move along the last direction is followed without delay;
  // a reversal must first cover the threshold, so a steady one-code dither
  // produces at most one step.
  always_comb begin
    st_next = st_reg;
    if (hys_code == `EOC_HYS_BYPASS) begin
      st_next.held = angle_in;
    end else if (diff != 12'sh000) begin
      if ((diff[11] == !st_reg.dir_up) || (mag >= thr)) begin
        st_next.held   = diff[11] ? 12'(st_reg.held - 12'h001) : 12'(st_reg.held + 12'h001);
        st_next.dir_up = !diff[11];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign angle_out = (hys_code == `EOC_HYS_BYPASS) ? angle_in : st_reg.held;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_bypass;
    hys_code == `EOC_HYS_BYPASS |-> angle_out == angle_in;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass hysteresis not direct");

  property p_dither_masked;
    (hys_code == `EOC_HYS_ZERO && $stable(hys_code) && mag == 12'h001
      && diff[11] == st_reg.dir_up) |=> $stable(angle_out);
  endproperty
  a_dither_masked: assert property (p_dither_masked) else $error("one LSB reversal passed");

  property p_reversal_follows;
    (hys_code != `EOC_HYS_BYPASS && $stable(hys_code) && mag >= 12'h004
      && mag < 12'h800) |=> (12'(angle_out - $past(angle_out)) == 12'h001
        || 12'(angle_out - $past(angle_out)) == 12'hFFF);
  endproperty
  a_reversal_follows: assert property (p_reversal_follows) else $error("large move held");

endmodule

// [verilog/eoc_core.sv]
// Output configuration registers and quadrature/commutation output logic.
`timescale 1ns/1ps
`include "eoc_consts.svh"

module eoc_core (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   user_mode,
  input  wire eoc_pkg::eoc_reg_req_t  reg_req,
  output logic [11:0]                 reg_rdata,
  input  wire eoc_pkg::eoc_nvm_image_t nvm_image,
  input  wire logic                   nvm_write_req,
  output logic                        nvm_write_grant,
  input  wire logic [11:0]            angle_in,
  output eoc_pkg::eoc_quad_pins_t     quad_pins,
  output eoc_pkg::eoc_comm_pins_t     comm_pins,
  output logic                        flux_check_en,
  output logic                        track_check_en
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    eoc_pkg::eoc_state_t fsm;
    eoc_pkg::eoc_qcfg_t  qcfg;
    logic [1:0]          lock;
    logic [1:0]          diag;
    eoc_pkg::eoc_ucfg_t  ucfg;
    logic [11:0]         rdata;
    eoc_pkg::eoc_quad_pins_t quad;
    eoc_pkg::eoc_comm_pins_t comm;
  } eoc_core_state_t;

  eoc_core_state_t st_reg;
  eoc_core_state_t st_next;

  logic [11:0] qfilt;
  logic [11:0] ufilt;
  logic [11:0] qang;
  logic [11:0] uang;
  logic [12:0] quad_edges;
  logic [24:0] quad_prod;
  logic [11:0] quad_pos;
  logic [5:0]  uvw_steps;
  logic [17:0] uvw_prod;
  logic [5:0]  uvw_raw;
  logic [5:0]  uvw_sector;
  logic        locked;
  logic        wr_ok;

  // ----------------------------------------------------------------------
  // Hysteresis filters
  // ----------------------------------------------------------------------
  eoc_hys_filter u_quad_hys (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .angle_in  (angle_in),
    .hys_code  (st_reg.qcfg.hys),
    .angle_out (qfilt)
  );

  eoc_hys_filter u_comm_hys (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .angle_in  (angle_in),
    .hys_code  (st_reg.ucfg.hys),
    .angle_out (ufilt)
  );

  // ----------------------------------------------------------------------
  // Position decoding
  // ----------------------------------------------------------------------
  // Quadrature edges per turn are four times the pulse count.
  function automatic logic [12:0] edges_for(input logic [3:0] code);
    case (code)
      4'h0:    edges_for = 13'h1000;
      4'h1:    edges_for = 13'h0800;
      4'h2:    edges_for = 13'h0400;
      4'h3:    edges_for = 13'h0200;
      4'h4:    edges_for = 13'h0FA0;
      4'h5:    edges_for = 13'h0E10;
      4'h6:    edges_for = 13'h0C80;
      4'h7:    edges_for = 13'h0AF0;
      4'h8:    edges_for = 13'h0960;
      4'h9:    edges_for = 13'h07D0;
      4'hA:    edges_for = 13'h0640;
      4'hB:    edges_for = 13'h05A0;
      4'hC:    edges_for = 13'h04B0;
      4'hD:    edges_for = 13'h0320;
      4'hE:    edges_for = 13'h0190;
      default: edges_for = 13'h00C8;
    endcase
  endfunction

  // Clockwise counting mirrors the angle so that it rises the other way.
  assign qang = st_reg.qcfg.dir ? 12'(12'h000 - qfilt) : qfilt;
  assign uang = st_reg.qcfg.dir ? 12'(12'h000 - ufilt) : ufilt;

  assign quad_edges = edges_for(st_reg.qcfg.res);
  assign quad_prod  = {13'h0000, qang} * {12'h000, quad_edges};
  assign quad_pos   = quad_prod[23:12];

  // Six commutation steps per electrical cycle, code plus one cycles per turn.
  assign uvw_steps  = 6'((st_reg.ucfg.res + 6'h01) * `EOC_UVW_SECTORS);
  assign uvw_prod   = {6'h00, uang} * {12'h000, uvw_steps};
  assign uvw_raw    = uvw_prod[17:12];
  assign uvw_sector = 6'(uvw_raw % `EOC_UVW_SECTORS);

  assign locked = (st_reg.lock != `EOC_LOCK_OPEN);
  assign wr_ok  = reg_req.wr && (st_reg.fsm == eoc_pkg::ST_USER);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Reads of these registers only answer in user mode; normal mode reads zero.
    st_next.rdata = 12'h000;
    if (reg_req.rd && st_reg.fsm == eoc_pkg::ST_USER) begin
      case (reg_req.addr)
        `EOC_OFS_QCFG: st_next.rdata = {2'h0, st_reg.qcfg};
        `EOC_OFS_LOCK: st_next.rdata = {10'h000, st_reg.lock};
        `EOC_OFS_DIAG: st_next.rdata = {10'h000, st_reg.diag};
        `EOC_OFS_UCFG: st_next.rdata = {5'h00, st_reg.ucfg};
        default:       st_next.rdata = 12'h000;
      endcase
    end

    case (st_reg.fsm)
      eoc_pkg::ST_BOOT: begin
        st_next.fsm = eoc_pkg::ST_RUN;
      end
      eoc_pkg::ST_RUN: begin
        if (user_mode) begin
          st_next.fsm = eoc_pkg::ST_USER;
        end
      end
      eoc_pkg::ST_USER: begin
        if (!user_mode) begin
          st_next.fsm = eoc_pkg::ST_RUN;
        end
      end
      default: begin
        st_next.fsm = eoc_pkg::ST_BOOT;
      end
    endcase

    // The lock mirror has no write path; only the memory copy sets it.
    if (wr_ok && user_mode) begin
      case (reg_req.addr)
        `EOC_OFS_QCFG: st_next.qcfg = reg_req.wdata[9:0];
        `EOC_OFS_DIAG: st_next.diag = reg_req.wdata[1:0];
        `EOC_OFS_UCFG: st_next.ucfg = reg_req.wdata[6:0];
        default: begin
        end
      endcase
    end

    // Power-up and every return to normal mode restore the stored settings,
    // discarding whatever was written while in user mode.
    if (st_reg.fsm == eoc_pkg::ST_BOOT ||
        (st_reg.fsm == eoc_pkg::ST_USER && !user_mode)) begin
      st_next.qcfg = nvm_image.qcfg[9:0];
      st_next.lock = nvm_image.lock[1:0];
      st_next.diag = nvm_image.diag[1:0];
      st_next.ucfg = nvm_image.ucfg[6:0];
    end

    // Quadrature phases follow a gray sequence of the edge position.
    st_next.quad.a = quad_pos[0] ^ quad_pos[1];
    st_next.quad.b = quad_pos[1];
    if (st_reg.qcfg.zmode) begin
      st_next.quad.z = (qang < `EOC_HALF_TURN);
    end else begin
      st_next.quad.z = (quad_pos[11:2] == 10'h000);
    end
    st_next.quad.oe = st_reg.qcfg.en;

    case (uvw_sector)
      6'h00:   {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h4;
      6'h01:   {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h6;
      6'h02:   {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h2;
      6'h03:   {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h3;
      6'h04:   {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h1;
      default: {st_next.comm.u, st_next.comm.v, st_next.comm.w} = 3'h5;
    endcase
    st_next.comm.oe = st_reg.ucfg.en;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg       <= '0;
      st_reg.fsm   <= eoc_pkg::ST_BOOT;
      st_reg.qcfg  <= `EOC_QCFG_RST;
      st_reg.lock  <= `EOC_LOCK_RST;
      st_reg.diag  <= `EOC_DIAG_RST;
      st_reg.ucfg  <= `EOC_UCFG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata       = st_reg.rdata;
  assign quad_pins       = st_reg.quad;
  assign comm_pins       = st_reg.comm;
  assign nvm_write_grant = nvm_write_req && !locked;
  assign flux_check_en   = !st_reg.diag[`EOC_DIAG_FLUX_BIT];
  assign track_check_en  = !st_reg.diag[`EOC_DIAG_TRK_BIT];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_reload;
    (st_reg.fsm == eoc_pkg::ST_USER && !user_mode) |=>
      (st_reg.qcfg == $past(nvm_image.qcfg[9:0]) && st_reg.lock == $past(nvm_image.lock[1:0]));
  endproperty
  a_reload: assert property (p_reload) else $error("settings not reloaded");

  property p_quad_hiz;
    !st_reg.qcfg.en |=> !quad_pins.oe;
  endproperty
  a_quad_hiz: assert property (p_quad_hiz) else $error("quadrature driven while off");

  property p_comm_hiz;
    !st_reg.ucfg.en |=> !comm_pins.oe;
  endproperty
  a_comm_hiz: assert property (p_comm_hiz) else $error("commutation driven while off");

  property p_lock_ro;
    (reg_req.wr && reg_req.addr == `EOC_OFS_LOCK && st_reg.fsm == eoc_pkg::ST_USER
      && user_mode) |=> $stable(st_reg.lock);
  endproperty
  a_lock_ro: assert property (p_lock_ro) else $error("lock mirror was written");

  property p_nvm_refuse;
    (st_reg.lock != `EOC_LOCK_OPEN) |-> !nvm_write_grant;
  endproperty
  a_nvm_refuse: assert property (p_nvm_refuse) else $error("write granted while locked");

  property p_diag_flux;
    (wr_ok && user_mode && reg_req.addr == `EOC_OFS_DIAG && reg_req.wdata[1])
      |=> !flux_check_en;
  endproperty
  a_diag_flux: assert property (p_diag_flux) else $error("flux check not disabled");

  property p_upper_zero;
    (reg_req.rd && reg_req.addr == `EOC_OFS_DIAG) |=> reg_rdata[11:2] == 10'h000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero");

  property p_switch_z;
    (st_reg.qcfg.zmode && !st_reg.qcfg.dir && $stable(st_reg.qcfg))
      |=> quad_pins.z == ($past(qfilt) < `EOC_HALF_TURN);
  endproperty
  a_switch_z: assert property (p_switch_z) else $error("switch index wrong");

  property p_comm_default;
    (st_reg.ucfg.res == 3'h2) |-> uvw_steps == 6'h12;
  endproperty
  a_comm_default: assert property (p_comm_default) else $error("commutation count wrong");

  property p_boot_load;
    (st_reg.fsm == eoc_pkg::ST_BOOT) |=>
      (st_reg.qcfg == $past(nvm_image.qcfg[9:0]) && st_reg.lock == $past(nvm_image.lock[1:0])
        && st_reg.diag == $past(nvm_image.diag[1:0])
        && st_reg.ucfg == $past(nvm_image.ucfg[6:0]));
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("settings not loaded");

  property p_run_frozen;
    (st_reg.fsm == eoc_pkg::ST_RUN) |=>
      ($stable(st_reg.qcfg) && $stable(st_reg.diag) && $stable(st_reg.ucfg));
  endproperty
  a_run_frozen: assert property (p_run_frozen) else $error("setting changed");

  property p_idle_read;
    (reg_req.rd && st_reg.fsm != eoc_pkg::ST_USER) |=> reg_rdata == 12'h000;
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("read not zero");

  property p_grant_open;
    (nvm_write_req && st_reg.lock == `EOC_LOCK_OPEN) |-> nvm_write_grant;
  endproperty
  a_grant_open: assert property (p_grant_open) else $error("write refused");

  property p_diag_track;
    (wr_ok && user_mode && reg_req.addr == `EOC_OFS_DIAG && reg_req.wdata[0])
      |=> !track_check_en;
  endproperty
  a_diag_track: assert property (p_diag_track) else $error("track check on");

  property p_quad_drive;
    st_reg.qcfg.en |=> quad_pins.oe;
  endproperty
  a_quad_drive: assert property (p_quad_drive) else $error("quadrature not driven");

  property p_comm_drive;
    st_reg.ucfg.en |=> comm_pins.oe;
  endproperty
  a_comm_drive: assert property (p_comm_drive) else $error("commutation not driven");

  property p_ucfg_read;
    (reg_req.rd && reg_req.addr == `EOC_OFS_UCFG && st_reg.fsm == eoc_pkg::ST_USER)
      |=> reg_rdata == {5'h00, $past(st_reg.ucfg)};
  endproperty
  a_ucfg_read: assert property (p_ucfg_read) else $error("commutation read wrong");

  c_user_exit: cover property (st_reg.fsm == eoc_pkg::ST_USER ##1 st_reg.fsm == eoc_pkg::ST_RUN);
  c_cfg_write: cover property (wr_ok && user_mode && reg_req.addr == `EOC_OFS_QCFG);
  c_refused:   cover property (nvm_write_req && !nvm_write_grant);
  c_quad_off:  cover property (!quad_pins.oe ##1 quad_pins.oe);
  c_boot_load: cover property (st_reg.fsm == eoc_pkg::ST_BOOT ##1 st_reg.fsm == eoc_pkg::ST_RUN);

endmodule

// [test/eoc_motor_ctrl.sv]
// Motor controller model that decodes the quadrature outputs into a signed position count.
`timescale 1ns/1ps

module eoc_motor_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  input  wire logic                    clr,
  input  wire eoc_pkg::eoc_quad_pins_t quad_pins,
  output logic signed [15:0]           count,
  output logic                         slip
);
  logic [1:0] ph_reg;
  logic [1:0] ph;

  // Released lines float high on their pull-ups, which decodes as phase two.
  assign ph = quad_pins.oe ? {quad_pins.b, quad_pins.a ^ quad_pins.b} : 2'h2;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= 2'h2;
      count  <= 16'sh0;
      slip   <= 1'b0;
    end else begin
      ph_reg <= ph;
      if (clr) begin
        count <= 16'sh0;
        slip  <= 1'b0;
      end else if (ph - ph_reg == 2'h1) begin
        count <= count + 16'sh1;
      end else if (ph - ph_reg == 2'h3) begin
        count <= count - 16'sh1;
      end else if (ph != ph_reg) begin
        // A jump of two phases cannot be decoded and means a lost position.
        slip <= 1'b1;
      end
    end
  end
endmodule

// [test/tb.sv]
// Self-checking testbench for the encoder output configuration block.
`timescale 1ns/1ps

module tb;
  logic                     clk_sys;
  logic                     arst_n;
  logic                     user_mode;
  eoc_pkg::eoc_reg_req_t    reg_req;
  logic [11:0]              reg_rdata;
  eoc_pkg::eoc_nvm_image_t  nvm_image;
  logic                     nvm_write_req;
  logic                     nvm_write_grant;
  logic [11:0]              angle_in;
  eoc_pkg::eoc_quad_pins_t  quad_pins;
  eoc_pkg::eoc_comm_pins_t  comm_pins;
  logic                     flux_check_en;
  logic                     track_check_en;
  logic                     clr;
  logic signed [15:0]       count;
  logic                     slip;
  int                       fails = 0;
  int                       checks = 0;
  int ppr_tab[16] = '{1024, 512, 256, 128, 1000, 900, 800, 700, 600, 500, 400, 360, 300,
                      200, 100, 50};
  int thr_tab[8] = '{1, 2, 2, 3, 4, 2, 2, 2};
  int ang_tab[4] = '{0, 683, 2048, 4095};
  logic [2:0] uvw_tab[6] = '{3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101};

  eoc_core eoc_core_i (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .user_mode       (user_mode),
    .reg_req         (reg_req),
    .reg_rdata       (reg_rdata),
    .nvm_image       (nvm_image),
    .nvm_write_req   (nvm_write_req),
    .nvm_write_grant (nvm_write_grant),
    .angle_in        (angle_in),
    .quad_pins       (quad_pins),
    .comm_pins       (comm_pins),
    .flux_check_en   (flux_check_en),
    .track_check_en  (track_check_en)
  );

  eoc_motor_ctrl eoc_motor_ctrl_i (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .clr       (clr),
    .quad_pins (quad_pins),
    .count     (count),
    .slip      (slip)
  );

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(negedge clk_sys);
    reg_req = {1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req = '0;
  endtask

  // Read data stands for one cycle only, so it is sampled at the first falling edge.
  task automatic rd(input logic [3:0] a, input logic [11:0] exp);
    @(negedge clk_sys);
    reg_req = {1'b0, 1'b1, a, 12'h000};
    @(negedge clk_sys);
    reg_req = '0;
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  task automatic clr_cnt;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
  endtask

  task automatic ramp(input int to);
    for (int a = 1; a <= to; a++) begin
      @(negedge clk_sys);
      angle_in = 12'(a);
    end
    tick(8);
  endtask

  task automatic zero_clr;
    angle_in = 12'h000;
    tick(4);
    clr_cnt();
  endtask

  task automatic give_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_boot;
    rd(4'h7, 12'h000);
    wr(4'h7, 12'h000);
    user_mode = 1'b1;
    tick(3);
    rd(4'h7, 12'h0A0);
    rd(4'h8, 12'h003);
    rd(4'h9, 12'h000);
    rd(4'hA, 12'h052);
    chk({15'h0, quad_pins.oe}, 16'h0001);
    chk({15'h0, comm_pins.oe}, 16'h0001);
    $display("boot test done");
  endtask

  task automatic t_regs;
    wr(4'h7, 12'hFFF);
    rd(4'h7, 12'h3FF);
    wr(4'h8, 12'h000);
    rd(4'h8, 12'h003);
    rd(4'h3, 12'h000);
    wr(4'hA, 12'hFFF);
    rd(4'hA, 12'h07F);
    wr(4'h9, 12'hFFF);
    rd(4'h9, 12'h003);
    chk({14'h0, flux_check_en, track_check_en}, 16'h0000);
    wr(4'h9, 12'h001);
    chk({14'h0, flux_check_en, track_check_en}, 16'h0002);
    wr(4'h9, 12'h002);
    chk({14'h0, flux_check_en, track_check_en}, 16'h0001);
    wr(4'h9, 12'h000);
    wr(4'h7, 12'h000);
    tick(2);
    chk({15'h0, quad_pins.oe}, 16'h0000);
    wr(4'h7, 12'h080);
    wr(4'hA, 12'h012);
    tick(2);
    chk({15'h0, comm_pins.oe}, 16'h0000);
    wr(4'hA, 12'h052);
    tick(2);
    chk({14'h0, quad_pins.oe, comm_pins.oe}, 16'h0003);
    $display("register test done");
  endtask

  // A dither smaller than the threshold must leave the count alone; one more LSB passes.
  task automatic t_hys;
    int thr;
    for (int c = 0; c < 8; c++) begin
      thr = thr_tab[c];
      wr(4'h7, 12'h080 | 12'(c << 4));
      angle_in = 12'h000;
      tick(4);
      ramp(100);
      clr_cnt();
      repeat (4) begin
        angle_in = 12'(101 - thr);
        tick(2);
        angle_in = 12'h064;
        tick(2);
      end
      tick(3);
      chk(count, 16'h0000);
      angle_in = 12'(100 - thr);
      tick(8);
      chk(count, 16'(-thr));
    end
    $display("hysteresis test done");
  endtask

  task automatic t_res;
    for (int c = 0; c < 16; c++) begin
      wr(4'h7, 12'h080 | 12'(c));
      zero_clr();
      ramp(2047);
      chk(count, 16'(2047 * 4 * ppr_tab[c] / 4096));
      chk({15'h0, slip}, 16'h0000);
    end
    $display("resolution test done");
  endtask

  task automatic t_index_dir;
    wr(4'h7, 12'h080);
    angle_in = 12'h000;
    tick(4);
    chk({15'h0, quad_pins.z}, 16'h0001);
    angle_in = 12'h010;
    tick(4);
    chk({15'h0, quad_pins.z}, 16'h0000);
    wr(4'h7, 12'h180);
    angle_in = 12'h7FF;
    tick(4);
    chk({15'h0, quad_pins.z}, 16'h0001);
    angle_in = 12'h800;
    tick(4);
    chk({15'h0, quad_pins.z}, 16'h0000);
    wr(4'h7, 12'h280);
    zero_clr();
    ramp(2047);
    chk(count, 16'(-2047));
    wr(4'h7, 12'h080);
    $display("index and direction test done");
  endtask

  task automatic t_uvw;
    for (int r = 0; r < 8; r++) begin
      wr(4'hA, 12'h040 | 12'(r));
      for (int i = 0; i < 4; i++) begin
        angle_in = 12'(ang_tab[i]);
        tick(4);
        chk({13'h0, comm_pins.u, comm_pins.v, comm_pins.w},
            {13'h0, uvw_tab[(ang_tab[i] * 6 * (r + 1) / 4096) % 6]});
      end
    end
    // A three LSB reversal at a sector edge is held off by the 4 LSB code.
    wr(4'hA, 12'h040);
    angle_in = 12'h2A4;
    tick(2);
    wr(4'hA, 12'h060);
    angle_in = 12'h2AB;
    tick(12);
    chk({13'h0, comm_pins.u, comm_pins.v, comm_pins.w}, {13'h0, uvw_tab[1]});
    angle_in = 12'h2A8;
    tick(8);
    chk({13'h0, comm_pins.u, comm_pins.v, comm_pins.w}, {13'h0, uvw_tab[1]});
    angle_in = 12'h2A7;
    tick(8);
    chk({13'h0, comm_pins.u, comm_pins.v, comm_pins.w}, {13'h0, uvw_tab[0]});
    $display("commutation test done");
  endtask

  task automatic t_reload;
    nvm_write_req = 1'b1;
    tick(1);
    chk({15'h0, nvm_write_grant}, 16'h0001);
    nvm_image.lock = 12'h001;
    user_mode = 1'b0;
    tick(3);
    chk({15'h0, nvm_write_grant}, 16'h0000);
    nvm_write_req = 1'b0;
    user_mode = 1'b1;
    tick(3);
    rd(4'h7, 12'h0A0);
    rd(4'h8, 12'h001);
    rd(4'hA, 12'h052);
    // A second power-up must load the stored copies, not the reset values.
    nvm_image.diag = 12'h002;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(3);
    rd(4'h8, 12'h001);
    rd(4'h9, 12'h002);
    chk({14'h0, flux_check_en, track_check_en}, 16'h0001);
    $display("reload test done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    user_mode = 1'b0;
    reg_req = '0;
    nvm_image = {12'hCA0, 12'hFF3, 12'h000, 12'hF52};
    nvm_write_req = 1'b0;
    angle_in = 12'h000;
    clr = 1'b0;
    tick(12);
    arst_n = 1'b1;
    tick(3);
    t_boot();
    t_regs();
    t_hys();
    t_res();
    t_index_dir();
    t_uvw();
    t_reload();
    give_verdict();
  end

  // The tests need about 40000 cycles; the limit leaves room for slow answers.
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    $display("watchdog expired at t=%0t", $time);
    give_verdict();
  end
endmodule
